// ---- hw/dac_cal_cfg.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 16-bit word bus with one register per even byte offset
//
// Operation
// - control value 0100H selects single DAC-register conversion
// - 8000H/8100H fetch offset upper/lower byte
// - 8200H/8300H fetch gain upper/lower byte
// - ready on bit 0, byte on 15:8
// - coefficients held in quarter-LSB units
// - coefficients stored as two's complement
// - channel 0 code register at 10H
// - 0001H to 0EH updates all converters together
`ifndef DAC_CAL_CFG_SVH
`define DAC_CAL_CFG_SVH
// =========================================
// register offsets (byte address bits 5:0, even offsets only)
`define OFS_MODE_CTRL 6'h00
`define OFS_FETCH_REQ 6'h0A
`define OFS_FETCH_RES 6'h0C
`define OFS_LAUNCH 6'h0E
`define OFS_CH0_CODE 6'h10
// =========================================
// values and fields
`define MODE_SINGLE_DACREG 16'h0100
`define MODE_RESET 16'h0000
`define LAUNCH_GO 16'h0001
`define FETCH_GO_BIT 15
`define FETCH_ADDR_MSB 14
`define FETCH_ADDR_LSB 8
`define RES_READY_BIT 0
`define CODE_RESET 16'h0000
// =========================================
// timing: calibration memory access time
`define CAL_ACCESS_NS 1000
`define CLK_PERIOD_NS 50
`define CAL_ACCESS_CYC ((`CAL_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- hw/dac_cal_pkg.sv ----
// types shared by the calibration readout design
// assumes the config header supplies all numeric constants
package dac_cal_pkg;
    // =========================================
    // fetch engine states
    typedef enum logic [1:0] {
        FETCH_IDLE = 2'b00,
        FETCH_WAIT = 2'b01,
        FETCH_DONE = 2'b10
    } fetch_state_t;
endpackage

// ---- hw/cal_byte_rom.sv ----
// calibration memory: holds factory coefficient bytes
// assumes a synchronous read, one cycle latency
`timescale 1ns/1ps
module cal_byte_rom #(
    parameter int ADDR_W = 7
) (
    input wire logic clk_in,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [7:0] data_out
);
    // =========================================
    // storage
    // two's complement words in quarter-LSB units, upper byte first
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = 8'h00;
        end
        // channel 0 offset -43, gain -185 as example factory data
        mem[0] = 8'hFF;
        mem[1] = 8'hD5;
        mem[2] = 8'hFF;
        mem[3] = 8'h47;
    end
    // registered read
    always_ff @(posedge clk_in) begin
        data_out <= mem[addr_in];
    end
endmodule

// ---- hw/dac_cal_top.sv ----
// register file, calibration fetch engine and simultaneous update
// assumes a host bus with one-cycle strobes, synchronous to clk_in
// the calibration memory is an internal byte array, so no memory
// pins leave the block
`include "dac_cal_cfg.svh"
`timescale 1ns/1ps
module dac_cal_top #(
    // number of converter channels, eight on the full build
    parameter int NUM_CH = 8,
    // byte address width of the calibration memory
    parameter int CAL_ADDR_W = 7,
    // memory access time in clock cycles
    parameter int ACCESS_CYC = `CAL_ACCESS_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [5:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic [16*NUM_CH-1:0] dac_code_out,
    output logic dac_load_out,
    output logic single_dacreg_mode_out
);
    // =========================================
    // elaboration checks: refuse sizes the logic cannot serve
    // more than eight channels would run past the last code register
    if (NUM_CH < 1 || NUM_CH > 8) begin
        $error("NUM_CH out of range");
    end
    // the wait counter is sixteen bits wide
    if (ACCESS_CYC < 1 || ACCESS_CYC > 65535) begin
        $error("ACCESS_CYC out of range");
    end
    // the byte address field of the request word is seven bits
    if (CAL_ADDR_W != 7) begin
        $error("CAL_ADDR_W must be 7");
    end

    // =========================================
    // decode
    // strobes are one cycle wide, so each decode fires once per access
    // writes to the status offset match nothing and fall away
    // a read and a write may share a cycle; they decode apart
    logic wr_mode, wr_fetch, wr_launch;
    logic [NUM_CH-1:0] wr_ch;
    assign wr_mode = wr_en_in && (addr_in == `OFS_MODE_CTRL);
    assign wr_fetch = wr_en_in && (addr_in == `OFS_FETCH_REQ);
    assign wr_launch = wr_en_in && (addr_in == `OFS_LAUNCH);
    // channel registers at 10H, 12H, ... one word each
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            wr_ch[c] = wr_en_in && (addr_in == 6'(`OFS_CH0_CODE + 2 * c));
        end
    end

    // =========================================
    // mode and trigger control
    // plain storage: the host reads back whatever it wrote
    // only the one single-conversion value is decoded into a mode
    // a write of any other value leaves the mode off
    logic [15:0] mode_q;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_q <= `MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= wdata_in;
        end
    end
    // single conversion from channel registers, all triggers on
    // registered so the output comes straight from a flip-flop,
    // at the cost of one cycle of lag after the control write
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            single_dacreg_mode_out <= 1'b0;
        end else begin
            single_dacreg_mode_out <= (mode_q == `MODE_SINGLE_DACREG);
        end
    end

    // =========================================
    // channel code registers, two's complement
    // the host writes corrected codes already limited to range
    // nothing reaches the converters until a launch
    logic [15:0] code_q [0:NUM_CH-1];
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int c = 0; c < NUM_CH; c++) begin
                code_q[c] <= `CODE_RESET;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (wr_ch[c]) begin
                    code_q[c] <= wdata_in;
                end
            end
        end
    end

    // =========================================
    // launch: all converters take their codes in the same cycle
    // a write of any other value is ignored
    // codes are copied in one edge so no converter leads another
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dac_code_out <= '0;
            dac_load_out <= 1'b0;
        end else begin
            // pulse low unless a launch is taken this cycle
            dac_load_out <= 1'b0;
            if (wr_launch && wdata_in == `LAUNCH_GO) begin
                for (int c = 0; c < NUM_CH; c++) begin
                    dac_code_out[16*c +: 16] <= code_q[c];
                end
                dac_load_out <= 1'b1;
            end
        end
    end

    // =========================================
    // coefficient fetch engine
    // bit 15 starts, bits 14:8 pick the byte (8000H..8300H for ch 0)
    // the access time is a fixed wait of ACCESS_CYC cycles; a slower
    // memory only needs a larger parameter
    dac_cal_pkg::fetch_state_t state_q;
    logic [CAL_ADDR_W-1:0] cal_addr_q;
    logic [15:0] wait_q;
    logic ready_q;
    logic [7:0] byte_q;
    logic [7:0] rom_byte;
    logic start;
    assign start = wr_fetch && wdata_in[`FETCH_GO_BIT];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            // idle with the first byte selected
            state_q <= dac_cal_pkg::FETCH_IDLE;
            cal_addr_q <= '0;
            wait_q <= '0;
        end else if (start) begin
            // a new start restarts even a fetch in flight
            cal_addr_q <= wdata_in[`FETCH_ADDR_MSB:`FETCH_ADDR_LSB];
            wait_q <= 16'(ACCESS_CYC);
            state_q <= dac_cal_pkg::FETCH_WAIT;
        end else begin
            // count down the access time, then hand over for one cycle
            case (state_q)
                dac_cal_pkg::FETCH_WAIT: begin
                    // last count: the memory byte has settled by now
                    if (wait_q <= 16'h0001) begin
                        state_q <= dac_cal_pkg::FETCH_DONE;
                    end else begin
                        wait_q <= wait_q - 16'h0001;
                    end
                end
                dac_cal_pkg::FETCH_DONE: begin
                    // one cycle to latch the byte, then back to idle
                    state_q <= dac_cal_pkg::FETCH_IDLE;
                end
                // idle and any stray code rest here
                default: begin
                    state_q <= dac_cal_pkg::FETCH_IDLE;
                end
            endcase
        end
    end

    // ready and byte; start clears ready so no stale byte looks valid
    // the byte is latched at the same edge as ready, so a poll that
    // sees ready high always sees the matching byte
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ready_q <= 1'b0;
            byte_q <= 8'h00;
        end else if (start) begin
            ready_q <= 1'b0;
            // otherwise ready holds until the next start
        end else if (state_q == dac_cal_pkg::FETCH_DONE) begin
            ready_q <= 1'b1;
            byte_q <= rom_byte;
        end
    end

    // calibration memory, read every cycle at the held address;
    // its registered output follows the address by one cycle
    cal_byte_rom #(.ADDR_W(CAL_ADDR_W)) u_rom (
        .clk_in(clk_in),
        .addr_in(cal_addr_q),
        .data_out(rom_byte)
    );

    // =========================================
    // read mux, registered; unmapped and write-only read as zero
    // data stands for the one cycle after the strobe, no wait state
    // idle cycles return zero so a stray sample reads nothing
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= 16'h0000;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_en_in;
            rdata_out <= 16'h0000;
            if (rd_en_in) begin
                if (addr_in == `OFS_MODE_CTRL) begin
                    // control reads back as written
                    rdata_out <= mode_q;
                end else if (addr_in == `OFS_FETCH_RES) begin
                    // status: byte on top, ready in bit 0
                    rdata_out <= {byte_q, 7'h00, ready_q};
                end
                // channel code registers, one word apart
                for (int c = 0; c < NUM_CH; c++) begin
                    if (addr_in == 6'(`OFS_CH0_CODE + 2 * c)) begin
                        rdata_out <= code_q[c];
                    end
                end
            end
        end
    end
endmodule

// ---- verification/dac_cal_top_props.sv ----
// checker on the ports of dac_cal_top
// assumes it is bound into dac_cal_top with its parameters
`timescale 1ns/1ps
module dac_cal_top_props #(
    parameter int NUM_CH = 8,
    parameter int ACCESS_CYC = 20
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [5:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic [16*NUM_CH-1:0] dac_code_out,
    input wire logic dac_load_out,
    input wire logic single_dacreg_mode_out
);
    // ==========
    // decoded requests, last ch0 write, age of the newest fetch
    wire go = wr_en_in && addr_in == 6'h0E && wdata_in == 16'h0001;
    wire fs = wr_en_in && addr_in == 6'h0A && wdata_in[15];
    wire st = rd_en_in && addr_in == 6'h0C;
    logic [15:0] ch0_q;
    logic [7:0] age_q; // zero until a fetch, saturates
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) ch0_q <= 16'h0000;
        else if (wr_en_in && addr_in == 6'h10) ch0_q <= wdata_in;
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) age_q <= 8'h00;
        else if (fs) age_q <= 8'h01;
        else if (age_q != 8'h00 && age_q != 8'hFF) age_q <= age_q + 8'h01;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_mode_select: assert property (
        wr_en_in && addr_in == 6'h00 && wdata_in == 16'h0100 ##1 !wr_en_in
        |=> single_dacreg_mode_out) else $error("mode not selected");
    a_launch_pulse: assert property (
        dac_load_out == $past(go)) else $error("load pulse wrong");
    a_code_hold: assert property (
        !dac_load_out |-> $stable(dac_code_out)) else $error("code moved");
    a_ch0_value: assert property (
        go |=> dac_code_out[15:0] == $past(ch0_q)) else $error("ch0 code");
    a_fetch_clear: assert property (
        fs ##2 st |=> !rdata_out[0]) else $error("stale ready");
    a_ready_set: assert property (
        st && age_q > ACCESS_CYC + 4 |=> rdata_out[0]
        && rdata_out[7:1] == 7'h00) else $error("ready missing");
    a_read_pulse: assert property (
        rvalid_out == $past(rd_en_in)) else $error("rvalid timing");
    a_idle_zero: assert property (
        !rvalid_out |-> rdata_out == 16'h0000) else $error("rdata idle");
endmodule
bind dac_cal_top dac_cal_top_props #(.NUM_CH(NUM_CH), .ACCESS_CYC(ACCESS_CYC))
    i_dac_cal_top_props (.clk_in(clk_in), .rstn_in(rstn_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .dac_code_out(dac_code_out), .dac_load_out(dac_load_out),
    .single_dacreg_mode_out(single_dacreg_mode_out));

// ---- verification/host_bfm.sv ----
// host side of the register bus: strobed writes, reads, fetches
// assumes clk_in from the bench; signals move 1 ns after an edge
`timescale 1ns/1ps
module host_bfm (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic wr_en_out = 1'b0,
    output logic rd_en_out = 1'b0,
    output logic [5:0] addr_out = 6'h00,
    output logic [15:0] wdata_out = 16'h0000
);
    // ==========
    // one-cycle strobes; released data is inverted so nothing leans on it
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_in) #1;
        {wr_en_out, addr_out, wdata_out} = {1'b1, a, d};
        @(posedge clk_in) #1;
        {wr_en_out, wdata_out} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_in) #1;
        {rd_en_out, addr_out} = {1'b1, a};
        @(posedge clk_in) #1;
        rd_en_out = 1'b0;
        d = rdata_in;
    endtask
    // polling is bounded so a stuck flag cannot hang the run
    task automatic fetch(input logic [6:0] sel, output logic [7:0] b);
        logic [15:0] s;
        s = 16'h0000;
        wr(6'h0A, {1'b1, sel, 8'h00});
        for (int i = 0; i < 40 && s[0] !== 1'b1; i++) rd(6'h0C, s);
        b = s[15:8];
    endtask
    task automatic coef(input logic [6:0] hi, output logic [15:0] c);
        fetch(hi, c[15:8]);
        fetch(hi + 7'h01, c[7:0]);
    endtask
    // limit the count in offset-binary terms before it is written
    function automatic logic [15:0] clamp(input int v);
        int u;
        u = v + 32768;
        if (u < 0) u = 0;
        if (u > 65535) u = 65535;
        return 16'(u - 32768);
    endfunction
endmodule

// ---- verification/tb_dac_cal_top.sv ----
// self-checking bench for dac_cal_top driven by host_bfm
// assumes the example coefficients held in the design's rom
`timescale 1ns/1ps
module tb_dac_cal_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr_en, rd_en, rvalid, load, mode;
    logic [5:0] addr;
    logic [15:0] wdata, rdata;
    logic [127:0] code;
    int miscompares = 0;
    int checks = 0;
    int loads = 0;
    int cyc = 0;
    always #25 clk_in = ~clk_in;
    dac_cal_top #(.NUM_CH(8), .CAL_ADDR_W(7), .ACCESS_CYC(20)) i_dac_cal_top (
        .clk_in(clk_in), .rstn_in(rstn_in), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .rvalid_out(rvalid), .dac_code_out(code),
        .dac_load_out(load), .single_dacreg_mode_out(mode));
    host_bfm i_host_bfm (.clk_in(clk_in), .rdata_in(rdata),
        .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
        .wdata_out(wdata));
    // ==========
    // load pulse count and hang guard
    always @(posedge clk_in) begin
        cyc++;
        if (load === 1'b1) loads++;
        if (cyc == 3000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk16(input string n, input logic [15:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_mode();
        logic [15:0] v;
        i_host_bfm.rd(6'h02, v);
        chk16("unmapped", 16'h0000, v);
        i_host_bfm.wr(6'h00, 16'h0100);
        i_host_bfm.rd(6'h00, v);
        chk16("mode on", 16'h0101, {v[15:1], mode});
        i_host_bfm.wr(6'h00, 16'h0200);
        i_host_bfm.rd(6'h00, v);
        chk16("mode off", 16'h0200, {v[15:1], mode});
    endtask
    // second start aborts the first, so only the newer byte may appear
    task automatic t_coef(output int off, output int gain);
        logic [15:0] c;
        logic [7:0] b;
        i_host_bfm.coef(7'h00, c);
        off = int'($signed(c));
        chk16("offset", 16'hFFD5, c);
        i_host_bfm.coef(7'h02, c);
        gain = int'($signed(c));
        chk16("gain", 16'hFF47, c);
        i_host_bfm.wr(6'h0A, 16'h8200);
        i_host_bfm.fetch(7'h01, b);
        chk16("abort", 16'h00D5, {8'h00, b});
        i_host_bfm.wr(6'h0A, 16'h0300);
        i_host_bfm.rd(6'h0C, c);
        chk16("no start", 16'hD501, c);
    endtask
    task automatic t_launch(input int off, input int gain);
        real r;
        logic [15:0] e;
        int n;
        r = -8192.0 * (1.0 + gain / 262144.0) + off / 4.0;
        e = i_host_bfm.clamp($rtoi(r - 0.5));
        chk16("corrected", 16'hDFFB, e);
        i_host_bfm.wr(6'h10, e);
        i_host_bfm.wr(6'h12, i_host_bfm.clamp(40000));
        i_host_bfm.wr(6'h14, i_host_bfm.clamp(-40000));
        chk16("held", 16'h0000, code[15:0]);
        n = loads;
        i_host_bfm.wr(6'h0E, 16'h0002);
        i_host_bfm.wr(6'h0E, 16'h0001);
        i_host_bfm.wr(6'h00, 16'h0100);
        chk16("loads", 16'h0001, 16'(loads - n));
        chk16("ch0", e, code[15:0]);
        chk16("ch1", 16'h7FFF, code[31:16]);
        chk16("ch2", 16'h8000, code[47:32]);
    endtask
    initial begin
        int off, gain;
        repeat (10) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        t_mode();
        t_coef(off, gain);
        t_launch(off, gain);
        stop_test();
    end
endmodule
